/* design/ecpl_pkg.sv */
// package for the echo peak level monitor: register indices, reset values, types
// assumes one clock domain and an apb master with 32-bit data, byte address = 4 * index
package ecpl_pkg;
	localparam int ADDR_W = 8;
	// register indices, word address = index * 4
	localparam logic [5:0] RIDX_A_RP_LO = 6'h0c;
	localparam logic [5:0] RIDX_A_RP_HI = 6'h0d;
	localparam logic [5:0] RIDX_A_SP_LO = 6'h0e;
	localparam logic [5:0] RIDX_A_SP_HI = 6'h0f;
	localparam logic [5:0] RIDX_A_EP_LO = 6'h10;
	localparam logic [5:0] RIDX_A_EP_HI = 6'h11;
	localparam logic [5:0] RIDX_A_DT_LO = 6'h14;
	localparam logic [5:0] RIDX_A_DT_HI = 6'h15;
	localparam logic [5:0] RIDX_B_RP_LO = 6'h2c;
	localparam logic [5:0] RIDX_B_RP_HI = 6'h2d;
	localparam logic [5:0] RIDX_B_SP_LO = 6'h2e;
	localparam logic [5:0] RIDX_B_SP_HI = 6'h2f;
	localparam logic [5:0] RIDX_B_EP_LO = 6'h30;
	localparam logic [5:0] RIDX_B_EP_HI = 6'h31;
	localparam logic [5:0] RIDX_B_DT_LO = 6'h34;
	localparam logic [5:0] RIDX_B_DT_HI = 6'h35;
	// double-talk threshold power-up, 0.5625 linear
	localparam logic [7:0] DT_LO_RST = 8'h00;
	localparam logic [7:0] DT_HI_RST = 8'h48;
	// peak value limits, two's complement
	localparam logic [15:0] PEAK_RST = 16'h0000;
	localparam logic [15:0] MAG_MAX = 16'h7fff;
	localparam logic [15:0] MOST_NEG = 16'h8000;
	// one canceller's sample group
	typedef struct packed {
		logic valid;
		logic [15:0] rin;
		logic [15:0] sin;
		logic [15:0] err;
	} ecpl_sample_t;
	// apb access state
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RESP = 2'b10
	} ecpl_state_t;
endpackage : ecpl_pkg

/* design/ecpl_monitor.sv */
// echo peak level monitor: peak trackers and double-talk thresholds for two cancellers
// assumes samples synchronous to clk and an apb master; one wait state on every access
//
// Overview of operation
// - receive peak bytes at 0d/0c and 2d/2c
// - send peak bytes, second at 2f/2e, 0e
// - error peak bytes, second canceller 31/30
// - error peak per canceller, first low 10
// - threshold low at 14/34, resets 00, high 48
// - send peak low at 0e, resets 00
`timescale 1ns/1ns
module ecpl_monitor
	import ecpl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// canceller samples
	input wire ecpl_sample_t sample_a,
	input wire ecpl_sample_t sample_b,
	// double-talk thresholds
	output logic [15:0] threshold_a,
	output logic [15:0] threshold_b
);
	ecpl_state_t state_reg;
	logic [15:0] peak_reg [6];
	logic [15:0] dt_reg [2];
	logic [15:0] smp [6];
	logic [15:0] mag [6];
	logic smp_vld [6];
	logic [5:0] clr;
	logic [5:0] idx;
	logic [7:0] rd_data;
	logic rd_hit;
	logic take;
	logic wr_ack;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	// absolute value, most negative saturates so peaks stay positive
	function automatic logic [15:0] ecpl_mag(input logic [15:0] s);
		logic [15:0] r;
		r = s;
		if (s == MOST_NEG) begin
			r = MAG_MAX;
		end else if (s[15]) begin
			r = 16'(~s + 16'h0001);
		end
		return r;
	endfunction : ecpl_mag

	// samples in tracker order: a rin, sin, err then b
	assign smp[0] = sample_a.rin;
	assign smp[1] = sample_a.sin;
	assign smp[2] = sample_a.err;
	assign smp[3] = sample_b.rin;
	assign smp[4] = sample_b.sin;
	assign smp[5] = sample_b.err;

	// apb decode
	assign idx = paddr[ADDR_W-1:2];
	assign take = (state_reg == ST_IDLE) && psel && penable;
	assign wr_ack = (state_reg == ST_RESP) && psel && penable && pwrite && rd_hit;

	// access state: idle until access phase, then one answer cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (take) begin
						state_reg <= ST_RESP;
					end
				end
				ST_RESP: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// read mux, 8-bit registers in the low lane
	always_comb begin
		rd_hit = 1'b1;
		rd_data = 8'h00;
		case (idx)
			RIDX_A_RP_LO: rd_data = peak_reg[0][7:0];
			RIDX_A_RP_HI: rd_data = peak_reg[0][15:8];
			RIDX_A_SP_LO: rd_data = peak_reg[1][7:0];
			RIDX_A_SP_HI: rd_data = peak_reg[1][15:8];
			RIDX_A_EP_LO: rd_data = peak_reg[2][7:0];
			RIDX_A_EP_HI: rd_data = peak_reg[2][15:8];
			RIDX_A_DT_LO: rd_data = dt_reg[0][7:0];
			RIDX_A_DT_HI: rd_data = dt_reg[0][15:8];
			RIDX_B_RP_LO: rd_data = peak_reg[3][7:0];
			RIDX_B_RP_HI: rd_data = peak_reg[3][15:8];
			RIDX_B_SP_LO: rd_data = peak_reg[4][7:0];
			RIDX_B_SP_HI: rd_data = peak_reg[4][15:8];
			RIDX_B_EP_LO: rd_data = peak_reg[5][7:0];
			RIDX_B_EP_HI: rd_data = peak_reg[5][15:8];
			RIDX_B_DT_LO: rd_data = dt_reg[1][7:0];
			RIDX_B_DT_HI: rd_data = dt_reg[1][15:8];
			default: rd_hit = 1'b0;
		endcase
	end

	// answer registers; unmapped address answers with pslverr and zero data
	always_ff @(posedge clk) begin
		if (reset) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= take;
			pslverr_reg <= take && !rd_hit;
			if (take) begin
				prdata_reg <= {24'h000000, rd_data};
			end
		end
	end
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// a write to a peak low byte restarts that measurement
	always_comb begin
		clr = 6'h00;
		if (wr_ack) begin
			case (idx)
				RIDX_A_RP_LO: clr[0] = 1'b1;
				RIDX_A_SP_LO: clr[1] = 1'b1;
				RIDX_A_EP_LO: clr[2] = 1'b1;
				RIDX_B_RP_LO: clr[3] = 1'b1;
				RIDX_B_SP_LO: clr[4] = 1'b1;
				RIDX_B_EP_LO: clr[5] = 1'b1;
				default: clr = 6'h00;
			endcase
		end
	end

	// magnitude per tracker
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_mag
			assign mag[g] = ecpl_mag(smp[g]);
			assign smp_vld[g] = (g < 3) ? sample_a.valid : sample_b.valid;
		end
	endgenerate

	// peak trackers; a sample in the clear cycle seeds the new peak so it is not lost
	always_ff @(posedge clk) begin
		for (int k = 0; k < 6; k++) begin
			if (reset) begin
				peak_reg[k] <= PEAK_RST;
			end else if (clr[k]) begin
				peak_reg[k] <= smp_vld[k] ? mag[k] : PEAK_RST;
			end else if (smp_vld[k] && (mag[k] > peak_reg[k])) begin
				peak_reg[k] <= mag[k];
			end
		end
	end

	// threshold registers, byte writes into 16-bit holders
	always_ff @(posedge clk) begin
		if (reset) begin
			dt_reg[0] <= {DT_HI_RST, DT_LO_RST};
			dt_reg[1] <= {DT_HI_RST, DT_LO_RST};
		end else if (wr_ack) begin
			case (idx)
				RIDX_A_DT_LO: dt_reg[0][7:0] <= pwdata[7:0];
				RIDX_A_DT_HI: dt_reg[0][15:8] <= pwdata[7:0];
				RIDX_B_DT_LO: dt_reg[1][7:0] <= pwdata[7:0];
				RIDX_B_DT_HI: dt_reg[1][15:8] <= pwdata[7:0];
				default: dt_reg[0] <= dt_reg[0];
			endcase
		end
	end
	assign threshold_a = dt_reg[0];
	assign threshold_b = dt_reg[1];

	// checks on the design's own outputs
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// thresholds: defaults after reset, byte writes land at the ready edge
	a_dt_default_val: assert property ($past(reset)
		|-> threshold_a == {DT_HI_RST, DT_LO_RST} && threshold_b == {DT_HI_RST, DT_LO_RST})
		else $error("threshold not at default after reset");
	a_dt_low_write: assert property (wr_ack && idx == RIDX_B_DT_LO
		|=> threshold_b[7:0] == $past(pwdata[7:0]))
		else $error("threshold low byte write lost");
	a_dt_high_write: assert property (wr_ack && idx == RIDX_A_DT_HI
		|=> threshold_a[15:8] == $past(pwdata[7:0]))
		else $error("threshold high byte write lost");
	// a threshold moves only on an acknowledged write, never on a read or an error
	a_dt_hold: assert property (!wr_ack
		|=> $stable(threshold_a) && $stable(threshold_b))
		else $error("threshold changed without a write");

	// receive peak lanes; data is what the byte held in the cycle the access was taken
	a_read_rp_a_lo: assert property (pready && !pwrite && idx == RIDX_A_RP_LO
		|-> prdata == {24'h000000, $past(peak_reg[0][7:0])})
		else $error("first receive peak low read wrong");
	a_read_rp_high: assert property (pready && !pwrite && idx == RIDX_A_RP_HI
		|-> prdata == {24'h000000, $past(peak_reg[0][15:8])})
		else $error("receive peak high read wrong");
	a_read_rp_b_lo: assert property (pready && !pwrite && idx == RIDX_B_RP_LO
		|-> prdata == {24'h000000, $past(peak_reg[3][7:0])})
		else $error("second receive peak low read wrong");
	a_read_rp_b_hi: assert property (pready && !pwrite && idx == RIDX_B_RP_HI
		|-> prdata == {24'h000000, $past(peak_reg[3][15:8])})
		else $error("second receive peak high read wrong");
	// send peak lanes
	a_read_sp_a: assert property (pready && !pwrite && idx == RIDX_A_SP_LO
		|-> prdata == {24'h000000, $past(peak_reg[1][7:0])})
		else $error("first send peak low read wrong");
	a_read_sp_a_hi: assert property (pready && !pwrite && idx == RIDX_A_SP_HI
		|-> prdata == {24'h000000, $past(peak_reg[1][15:8])})
		else $error("first send peak high read wrong");
	a_read_sp_b_lo: assert property (pready && !pwrite && idx == RIDX_B_SP_LO
		|-> prdata == {24'h000000, $past(peak_reg[4][7:0])})
		else $error("second send peak low read wrong");
	a_read_sp_b: assert property (pready && !pwrite && idx == RIDX_B_SP_HI
		|-> prdata == {24'h000000, $past(peak_reg[4][15:8])})
		else $error("second send peak high read wrong");
	// error peak lanes
	a_read_ep_a: assert property (pready && !pwrite && idx == RIDX_A_EP_LO
		|-> prdata == {24'h000000, $past(peak_reg[2][7:0])})
		else $error("first error peak low read wrong");
	a_read_ep_a_hi: assert property (pready && !pwrite && idx == RIDX_A_EP_HI
		|-> prdata == {24'h000000, $past(peak_reg[2][15:8])})
		else $error("first error peak high read wrong");
	a_read_ep_b: assert property (pready && !pwrite && idx == RIDX_B_EP_LO
		|-> prdata == {24'h000000, $past(peak_reg[5][7:0])})
		else $error("second error peak low read wrong");
	a_read_ep_b_hi: assert property (pready && !pwrite && idx == RIDX_B_EP_HI
		|-> prdata == {24'h000000, $past(peak_reg[5][15:8])})
		else $error("second error peak high read wrong");
	// threshold lanes
	a_read_dt_a_lo: assert property (pready && !pwrite && idx == RIDX_A_DT_LO
		|-> prdata == {24'h000000, $past(dt_reg[0][7:0])})
		else $error("first threshold low read wrong");
	a_read_dt_b_hi: assert property (pready && !pwrite && idx == RIDX_B_DT_HI
		|-> prdata == {24'h000000, $past(dt_reg[1][15:8])})
		else $error("second threshold high read wrong");
	// byte registers: upper lanes of the bus word stay zero
	a_read_upper_zero: assert property (pready
		|-> prdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	// only an unmapped index answers with an error
	a_unmapped_err: assert property (pready
		|-> pslverr == !rd_hit)
		else $error("error response on wrong index");

	// a larger magnitude always replaces the held peak
	a_peak_track_up: assert property (sample_a.valid && !clr[0] && mag[0] > peak_reg[0]
		|=> peak_reg[0] == $past(mag[0]))
		else $error("receive peak missed a larger sample");
	a_peak_track_b: assert property (sample_b.valid && !clr[5] && mag[5] > peak_reg[5]
		|=> peak_reg[5] == $past(mag[5]))
		else $error("second error peak missed a larger sample");
	// without a clear the peak can only grow
	a_peak_no_drop: assert property (!clr[4]
		|=> peak_reg[4] >= $past(peak_reg[4]))
		else $error("send peak fell without a clear");
	// clear and sample in one cycle: the sample seeds the new peak
	a_peak_clear_seed: assert property (clr[3]
		|=> peak_reg[3] == ($past(sample_b.valid) ? $past(mag[3]) : PEAK_RST))
		else $error("cleared peak not seeded correctly");
	// saturation keeps every peak positive
	a_peak_in_range: assert property (1'b1
		|-> peak_reg[0] <= MAG_MAX && peak_reg[5] <= MAG_MAX)
		else $error("peak outside positive range");
	// no sample and no clear: reads leave the peak untouched
	a_read_no_effect: assert property (!sample_a.valid && !clr[0]
		|=> $stable(peak_reg[0]))
		else $error("peak changed without a sample");

	// bus timing: one wait state, single-cycle answer
	a_resp_one_cycle: assert property (psel && penable && !pready ##1 psel && penable
		|-> pready ##1 !pready)
		else $error("apb answer not a single cycle");
	// no answer without a taken access
	a_ready_needs_access: assert property (pready
		|-> $past(take))
		else $error("ready without an access");

	// main scenarios worth seeing
	c_read_access: cover property (pready && !pwrite && !pslverr);
	c_thresh_write: cover property (wr_ack && idx == RIDX_A_DT_HI);
	c_clear_with_sample: cover property (clr[3] && sample_b.valid);
	c_unmapped: cover property (pready && pslverr);
	c_peak_saturate: cover property (sample_a.valid && smp[0] == MOST_NEG);
endmodule : ecpl_monitor

/* sim/echo_peak_level_monitor_tb.sv */
// self-checking bench for the echo peak level monitor: apb reads and writes, random samples
// assumes ecpl_pkg and ecpl_monitor are compiled first; one idle cycle between apb transfers
`timescale 1ns/1ns
module echo_peak_level_monitor_tb;
	import ecpl_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, r, seed = 32'h21;
	ecpl_sample_t sample_a = '0, sample_b = '0;
	logic [15:0] threshold_a, threshold_b, t;
	logic [15:0] pk [6];
	logic [5:0] lo_idx [6] = '{6'h0c, 6'h0e, 6'h10, 6'h2c, 6'h2e, 6'h30};
	int errors = 0, check_count = 0, cycles = 0;
	always #4 clk = ~clk;
	ecpl_monitor dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_a(sample_a), .sample_b(sample_b), .threshold_a(threshold_a), .threshold_b(threshold_b));
	// xorshift keeps the run repeatable
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// magnitude with the most negative value saturated
	function automatic logic [15:0] mag(input logic [15:0] x);
		return (x == MOST_NEG) ? MAG_MAX : (x[15] ? -x : x);
	endfunction : mag
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one apb transfer; waits on pready, never assumes the wait-state count
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
		rd = prdata;
		e = pslverr;
		if (n >= 50) check(32'h1, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	// hang guard, generous against the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// power-up values of thresholds and peaks
		check({threshold_b, threshold_a}, {DT_HI_RST, DT_LO_RST, DT_HI_RST, DT_LO_RST});
		apb(1'b0, RIDX_A_DT_LO, 8'h00); check(rd, 32'h00);
		apb(1'b0, RIDX_B_DT_HI, 8'h00); check(rd, 32'h48);
		apb(1'b0, RIDX_B_SP_LO, 8'h00); check(rd, 32'h00);
		$display("test reset done");
		// random thresholds, both bytes, both cancellers
		repeat (4) begin
			t = 16'(rnd());
			apb(1'b1, RIDX_A_DT_LO, t[7:0]);
			apb(1'b1, RIDX_A_DT_HI, t[15:8]);
			apb(1'b1, RIDX_B_DT_LO, ~t[7:0]);
			apb(1'b1, RIDX_B_DT_HI, ~t[15:8]);
			check({threshold_a, threshold_b}, {t, ~t});
			apb(1'b0, RIDX_B_DT_LO, 8'h00); check(rd, {24'h0, ~t[7:0]});
		end
		$display("test threshold done");
		// random samples with the most negative value first
		foreach (pk[i]) pk[i] = PEAK_RST;
		for (int k = 0; k < 40; k++) begin
			r = (k == 0) ? {16'h1234, MOST_NEG} : rnd();
			t = 16'(rnd());
			sample_a <= {r[0] | (k == 0), r[15:0], r[31:16], t};
			sample_b <= {t[3], ~t, r[15:0], r[31:16]};
			if (r[0] | (k == 0)) begin
				pk[0] = mag(r[15:0]) > pk[0] ? mag(r[15:0]) : pk[0];
				pk[1] = mag(r[31:16]) > pk[1] ? mag(r[31:16]) : pk[1];
				pk[2] = mag(t) > pk[2] ? mag(t) : pk[2];
			end
			if (t[3]) begin
				pk[3] = mag(~t) > pk[3] ? mag(~t) : pk[3];
				pk[4] = mag(r[15:0]) > pk[4] ? mag(r[15:0]) : pk[4];
				pk[5] = mag(r[31:16]) > pk[5] ? mag(r[31:16]) : pk[5];
			end
			@(posedge clk);
		end
		sample_a <= '0;
		sample_b <= '0;
		@(posedge clk);
		// low, high, then low again: a read must not disturb the peak
		foreach (pk[i]) begin
			apb(1'b0, lo_idx[i], 8'h00); check(rd, {24'h0, pk[i][7:0]});
			apb(1'b0, lo_idx[i] + 6'h01, 8'h00); check(rd, {24'h0, pk[i][15:8]});
			apb(1'b0, lo_idx[i], 8'h00); check(rd, {24'h0, pk[i][7:0]});
		end
		$display("test peaks done");
		// read-only high byte ignores writes, low byte write clears, unmapped index errors
		apb(1'b1, RIDX_B_RP_HI, 8'hff); check(e, 1'b0);
		apb(1'b0, RIDX_B_RP_HI, 8'h00); check(rd, {24'h0, pk[3][15:8]});
		apb(1'b1, RIDX_B_RP_LO, 8'h5a);
		apb(1'b0, RIDX_B_RP_HI, 8'h00); check(rd, 32'h0);
		apb(1'b0, 6'h00, 8'h00); check({31'h0, e}, 32'h1);
		check(rd, 32'h0);
		$display("test access done");
		results();
	end
endmodule : echo_peak_level_monitor_tb
